/* File: verilog/osx_consts.vh */
/*
 Constants for the output scale, offset and expand datapath:
 register offsets, field positions, reset values and number scales.
 Assumes it is included by bare name from the design files.
*/
`ifndef OSX_CONSTS_VH
`define OSX_CONSTS_VH

// Register byte offsets
`define OSX_A_CTRL     8'h00
`define OSX_A_SENS     8'h04
`define OSX_A_STEP     8'h08
`define OSX_A_CMD      8'h0c
`define OSX_A_OFS_X    8'h10
`define OSX_A_OFS_Y    8'h14
`define OSX_A_OFS_R    8'h18
`define OSX_A_MODE     8'h1c
`define OSX_A_STAT     8'h20

// Control bits
`define OSX_CTRL_PRI_R   0
`define OSX_CTRL_SEC_PH  1

// Command bits
`define OSX_CMD_TOGGLE   0
`define OSX_CMD_INC      1
`define OSX_CMD_DEC      2
`define OSX_CMD_AUTO     3
`define OSX_CMD_RATIO    4
`define OSX_CMD_EXPAND   5
`define OSX_CMD_CHAN     8

// Per-quantity mode nibble: {expand[1:0], ratio, offset on}
`define OSX_MODE_OFS     0
`define OSX_MODE_RAT     1
`define OSX_MODE_EXP     2
`define OSX_MODE_W       4

// Expand codes
`define OSX_EXP_X1       2'h0
`define OSX_EXP_X10      2'h1
`define OSX_EXP_X100     2'h2

// Reset values
`define OSX_SENS_RST     24'h0f4240
`define OSX_STEP_RST     18'h00064
`define OSX_OFS_RST      18'h00000

// Scales: full scale is 100.00 %, offsets reach +-999.00 %
`define OSX_FS_PCT       64'sh2710
`define OSX_OFS_MAX      64'sh1863c
`define OSX_FS_CODE      64'sh7530
`define OSX_AUX_UNIT     64'sh3e8
`define OSX_PH_FS        64'sh2bf20
`define OSX_STRIP_MAX    64'sh7fffffff

`endif

/* File: verilog/osx_path.v */
/*
 One quantity's output chain: normalise to sensitivity, subtract offset,
 divide by the auxiliary ratio input, expand and scale to full scale.
 Purely combinational; the caller registers the results per sample.
*/
`timescale 1ns/1ps
`default_nettype none
`include "osx_consts.vh"
module osx_path (
	input  wire signed [23:0] q,
	input  wire        [23:0] sens,
	input  wire signed [17:0] ofs,
	input  wire        [3:0]  mode,
	input  wire signed [15:0] aux,
	output wire signed [15:0] out_code,
	output wire signed [15:0] bar,
	output wire signed [31:0] strip,
	output wire signed [17:0] auto_ofs,
	output wire        [3:0]  flags
);
	wire signed [63:0] qx;      // Quantity, sign extended
	wire signed [63:0] sd;      // Sensitivity, zero guarded
	wire signed [63:0] norm;    // Quantity in 0.01 % of full scale
	wire signed [63:0] diff;    // After offset
	wire signed [63:0] rat;     // After ratio
	wire signed [63:0] expd;    // After expand
	wire signed [63:0] clip;    // Pinned to full scale
	wire signed [63:0] aux_x;   // Aux input in mV
	wire               ovl;     // Beyond +-10 V
	wire [1:0]         ex;      // Expand code
	wire signed [63:0] oc;      // Output code before narrowing

	assign ex    = mode[`OSX_MODE_EXP+1:`OSX_MODE_EXP];
	assign qx    = q;
	assign sd    = (sens == 24'h0) ? 64'sh1 : $signed({40'h0, sens});
	assign aux_x = aux;
	// Normalise, so a quantity equal to sensitivity is full scale
	assign norm  = (qx * `OSX_FS_PCT) / sd;
	// Stored percentage applies only while switched on
	assign diff  = mode[`OSX_MODE_OFS] ? norm - $signed({{46{ofs[17]}}, ofs}) : norm;
	// A dead aux input cannot be divided by; it pins the output instead
	assign rat   = !mode[`OSX_MODE_RAT] ? diff :
		(aux == 16'h0) ? ((diff < 0) ? -`OSX_STRIP_MAX : `OSX_STRIP_MAX) :
		(diff * `OSX_AUX_UNIT) / aux_x;
	assign expd  = (ex == `OSX_EXP_X10) ? rat * 64'sha :
		(ex == `OSX_EXP_X100) ? rat * 64'sh64 : rat;
	assign ovl   = (expd > `OSX_FS_PCT) || (expd < -`OSX_FS_PCT);
	// Pin rather than wrap
	assign clip  = (expd > `OSX_FS_PCT) ? `OSX_FS_PCT :
		(expd < -`OSX_FS_PCT) ? -`OSX_FS_PCT : expd;
	assign bar      = clip[15:0];
	assign oc       = (clip * `OSX_FS_CODE) / `OSX_FS_PCT;
	// Clamped value always fits in sixteen bits
	assign out_code = oc[15:0];
	// Strip values keep offset and ratio but never expand
	assign strip = (rat > `OSX_STRIP_MAX) ? 32'h7fffffff :
		(rat < -`OSX_STRIP_MAX) ? 32'h80000001 : rat[31:0];
	// Offset that zeroes the quantity, limited to the offset range
	assign auto_ofs = (norm > `OSX_OFS_MAX) ? 18'h1863c :
		(norm < -`OSX_OFS_MAX) ? 18'h279c4 : norm[17:0];
	// Overload, offset, ratio, expand display flags
	assign flags = {ex != `OSX_EXP_X1, mode[`OSX_MODE_RAT],
		mode[`OSX_MODE_OFS] && (ofs != 18'h0), ovl};
endmodule
`default_nettype wire

/* File: verilog/osx_top.v */
/*
 Output scale, offset and expand block of a lock-in instrument:
 channel source routing, per-quantity offset, ratio and expand state,
 adjustment commands, overload and indicator flags, phase scaling.
 Assumes detector samples and the aux input arrive on CORE_CLK with a
 one-cycle SAMPLE_VALID, and a plain register port on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "osx_consts.vh"
module osx_top #(
	parameter QN = 3
) (
	input  wire               CORE_CLK,
	input  wire               RESET,
	input  wire               SAMPLE_VALID,
	input  wire signed [23:0] X_IN,
	input  wire signed [23:0] Y_IN,
	input  wire signed [23:0] R_IN,
	input  wire signed [18:0] PHASE_IN,
	input  wire signed [15:0] AUX_IN,
	input  wire        [7:0]  ADDR,
	input  wire        [31:0] WR_DATA,
	input  wire               WR_STB,
	input  wire               RD_STB,
	output reg         [31:0] RD_DATA,
	output reg  signed [15:0] PRI_OUT,
	output reg  signed [15:0] SEC_OUT,
	output reg  signed [15:0] X_OUT,
	output reg  signed [15:0] Y_OUT,
	output reg  signed [15:0] PRI_BAR,
	output reg  signed [15:0] SEC_BAR,
	output reg  signed [31:0] PRI_STRIP,
	output reg  signed [31:0] SEC_STRIP,
	output reg                OUT_VALID,
	output reg                OVERLOAD_LED,
	output reg                PRI_OFFSET_LED,
	output reg                SEC_OFFSET_LED,
	output reg                PRI_RATIO_LED,
	output reg                SEC_RATIO_LED,
	output reg                PRI_EXPAND_LED,
	output reg                SEC_EXPAND_LED,
	output reg         [11:0] DISP_FLAGS
);
	localparam QX = 0;          // Quantity index of X
	localparam QY = 1;          // Quantity index of Y
	localparam QR = 2;          // Quantity index of R

	reg  [1:0]  ctrl_reg;       // Channel source selections
	reg  [23:0] sens_reg;       // Sensitivity in quantity units
	reg  [17:0] step_reg;       // Knob step, 0.01 % units
	reg  [17:0] ofs_reg  [0:QN-1]; // Stored offset percentages
	reg  [3:0]  mode_reg [0:QN-1]; // Per-quantity mode nibbles

	wire signed [23:0] q_in [0:QN-1]; // Measured quantities
	wire signed [15:0] p_out   [0:QN-1];
	wire signed [15:0] p_bar   [0:QN-1];
	wire signed [31:0] p_strip [0:QN-1];
	wire signed [17:0] p_auto  [0:QN-1];
	wire        [3:0]  p_flags [0:QN-1];

	wire        pri_r;          // Primary shows R
	wire        sec_ph;         // Secondary shows phase
	wire        cmd_wr;         // Command register written
	wire        cmd_chan;       // Command addresses secondary
	wire        cmd_refused;    // Command aimed at phase
	wire [1:0]  tgt;            // Quantity the command adjusts
	wire [3:0]  tmode;          // Its mode nibble
	wire signed [17:0] tofs;    // Its stored offset
	wire signed [19:0] ofs_up;  // Offset plus step
	wire signed [19:0] ofs_dn;  // Offset minus step
	wire signed [63:0] ph_scl;  // Scaled phase
	wire signed [15:0] ph_code; // Phase output code
	wire signed [15:0] ph_bar;  // Phase bar, full scale at 180 deg
	wire signed [63:0] ph_pct;  // Phase in 0.01 % of full scale

	assign q_in[QX] = X_IN;
	assign q_in[QY] = Y_IN;
	assign q_in[QR] = R_IN;
	assign pri_r    = ctrl_reg[`OSX_CTRL_PRI_R];
	assign sec_ph   = ctrl_reg[`OSX_CTRL_SEC_PH];
	assign cmd_wr   = WR_STB && (ADDR == `OSX_A_CMD);
	assign cmd_chan = WR_DATA[`OSX_CMD_CHAN];

	// Adjusted quantity follows the source selection of the channel
	assign tgt = cmd_chan ? QY[1:0] : (pri_r ? QR[1:0] : QX[1:0]);
	// Phase has no offset, ratio or expand of its own
	assign cmd_refused = cmd_chan && sec_ph;
	assign tmode  = mode_reg[tgt];
	assign tofs   = ofs_reg[tgt];
	assign ofs_up = {{2{tofs[17]}}, tofs} + $signed({2'h0, step_reg});
	assign ofs_dn = {{2{tofs[17]}}, tofs} - $signed({2'h0, step_reg});

	// Phase in millidegrees; 19 bits so that +-180 deg is representable
	assign ph_scl  = ($signed({{45{PHASE_IN[18]}}, PHASE_IN}) * `OSX_FS_CODE) / `OSX_PH_FS;
	assign ph_pct  = ($signed({{45{PHASE_IN[18]}}, PHASE_IN}) * `OSX_FS_PCT) / `OSX_PH_FS;
	assign ph_code = ph_scl[15:0];
	// Bar counts in 0.01 % units like the other quantities
	assign ph_bar  = ph_pct[15:0];

	// One chain per quantity, each with its own offset and mode
	genvar gi;
	generate
		for (gi = 0; gi < QN; gi = gi + 1) begin : g_q
			osx_path u_path (
				.q        (q_in[gi]),
				.sens     (sens_reg),
				.ofs      (ofs_reg[gi]),
				.mode     (mode_reg[gi]),
				.aux      (AUX_IN),
				.out_code (p_out[gi]),
				.bar      (p_bar[gi]),
				.strip    (p_strip[gi]),
				.auto_ofs (p_auto[gi]),
				.flags    (p_flags[gi])
			);

			// Per-quantity settings: bus writes and front-panel commands
			always @(posedge CORE_CLK) begin
				if (RESET) begin
					ofs_reg[gi]  <= `OSX_OFS_RST;
					mode_reg[gi] <= 4'h0;
				end else if (WR_STB && (ADDR == (`OSX_A_OFS_X + gi * 4))) begin
					// Keypad entry; outside the offset range is ignored
					if (($signed(WR_DATA) <= $signed(32'h1863c)) &&
						($signed(WR_DATA) >= $signed(32'hfffe79c4))) begin
						ofs_reg[gi] <= WR_DATA[17:0];
					end
				end else if (WR_STB && (ADDR == `OSX_A_MODE)) begin
					// Code 3 for expand is not a valid factor; keep old one
					if (WR_DATA[gi*4+3 -: 2] != 2'h3) begin
						mode_reg[gi] <= WR_DATA[gi*4+3 -: 4];
					end else begin
						mode_reg[gi][1:0] <= WR_DATA[gi*4+1 -: 2];
					end
				end else if (cmd_wr && !cmd_refused && (tgt == gi)) begin
					if (WR_DATA[`OSX_CMD_TOGGLE]) begin
						// Switch only; stored percentage stays
						mode_reg[gi][`OSX_MODE_OFS] <= ~mode_reg[gi][`OSX_MODE_OFS];
					end else if (WR_DATA[`OSX_CMD_INC]) begin
						// Knob works even while the offset is off
						ofs_reg[gi] <= (ofs_up > $signed(20'h1863c)) ? 18'h1863c : ofs_up[17:0];
					end else if (WR_DATA[`OSX_CMD_DEC]) begin
						ofs_reg[gi] <= (ofs_dn < $signed(20'he79c4)) ? 18'h279c4 : ofs_dn[17:0];
					end else if (WR_DATA[`OSX_CMD_AUTO]) begin
						ofs_reg[gi] <= p_auto[gi];
					end else if (WR_DATA[`OSX_CMD_RATIO]) begin
						// Only one aux source: ratio is off or on
						mode_reg[gi][`OSX_MODE_RAT] <= ~mode_reg[gi][`OSX_MODE_RAT];
					end else if (WR_DATA[`OSX_CMD_EXPAND]) begin
						case (tmode[3:2])
							`OSX_EXP_X1:  mode_reg[gi][3:2] <= `OSX_EXP_X10;
							`OSX_EXP_X10: mode_reg[gi][3:2] <= `OSX_EXP_X100;
							default:      mode_reg[gi][3:2] <= `OSX_EXP_X1;
						endcase
					end
				end
			end
		end
	endgenerate

	// Shared settings; sensitivity writes leave offsets alone
	always @(posedge CORE_CLK) begin
		if (RESET) begin
			ctrl_reg <= 2'h0;
			sens_reg <= `OSX_SENS_RST;
			step_reg <= `OSX_STEP_RST;
		end else if (WR_STB) begin
			if (ADDR == `OSX_A_CTRL) begin
				ctrl_reg <= WR_DATA[1:0];
			end else if (ADDR == `OSX_A_SENS) begin
				sens_reg <= WR_DATA[23:0];
			end else if (ADDR == `OSX_A_STEP) begin
				step_reg <= WR_DATA[17:0];
			end
		end
	end

	// Register read port: data only in the cycle after the strobe
	always @(posedge CORE_CLK) begin
		if (RESET) begin
			RD_DATA <= 32'h0;
		end else if (RD_STB) begin
			if (ADDR == `OSX_A_CTRL) begin
				RD_DATA <= {30'h0, ctrl_reg};
			end else if (ADDR == `OSX_A_SENS) begin
				RD_DATA <= {8'h0, sens_reg};
			end else if (ADDR == `OSX_A_STEP) begin
				RD_DATA <= {14'h0, step_reg};
			end else if (ADDR == `OSX_A_OFS_X) begin
				RD_DATA <= {{14{ofs_reg[QX][17]}}, ofs_reg[QX]};
			end else if (ADDR == `OSX_A_OFS_Y) begin
				RD_DATA <= {{14{ofs_reg[QY][17]}}, ofs_reg[QY]};
			end else if (ADDR == `OSX_A_OFS_R) begin
				RD_DATA <= {{14{ofs_reg[QR][17]}}, ofs_reg[QR]};
			end else if (ADDR == `OSX_A_MODE) begin
				RD_DATA <= {20'h0, mode_reg[QR], mode_reg[QY], mode_reg[QX]};
			end else if (ADDR == `OSX_A_STAT) begin
				RD_DATA <= {19'h0, OVERLOAD_LED, DISP_FLAGS};
			end else begin
				// Command register and unmapped offsets read zero
				RD_DATA <= 32'h0;
			end
		end else begin
			RD_DATA <= 32'h0;
		end
	end

	// Outputs refresh once per sample, overload in the same cycle
	always @(posedge CORE_CLK) begin
		if (RESET) begin
			PRI_OUT      <= 16'h0;
			SEC_OUT      <= 16'h0;
			X_OUT        <= 16'h0;
			Y_OUT        <= 16'h0;
			PRI_BAR      <= 16'h0;
			SEC_BAR      <= 16'h0;
			PRI_STRIP    <= 32'h0;
			SEC_STRIP    <= 32'h0;
			OUT_VALID    <= 1'b0;
			OVERLOAD_LED <= 1'b0;
			DISP_FLAGS   <= 12'h0;
		end else begin
			OUT_VALID <= SAMPLE_VALID;
			if (SAMPLE_VALID) begin
				// Dedicated outputs ignore the source selections
				X_OUT <= p_out[QX];
				Y_OUT <= p_out[QY];
				if (pri_r) begin
					PRI_OUT   <= p_out[QR];
					PRI_BAR   <= p_bar[QR];
					PRI_STRIP <= p_strip[QR];
				end else begin
					PRI_OUT   <= p_out[QX];
					PRI_BAR   <= p_bar[QX];
					PRI_STRIP <= p_strip[QX];
				end
				if (sec_ph) begin
					SEC_OUT   <= ph_code;
					SEC_BAR   <= ph_bar;
					SEC_STRIP <= {{13{PHASE_IN[18]}}, PHASE_IN};
				end else begin
					SEC_OUT   <= p_out[QY];
					SEC_BAR   <= p_bar[QY];
					SEC_STRIP <= p_strip[QY];
				end
				// Any driven output beyond full scale lights overload
				OVERLOAD_LED <= p_flags[QX][0] || p_flags[QY][0] ||
					(pri_r && p_flags[QR][0]);
				DISP_FLAGS <= {p_flags[QR], p_flags[QY], p_flags[QX]};
			end
		end
	end

	// Channel indicators follow the quantity each channel selects
	always @(posedge CORE_CLK) begin
		if (RESET) begin
			PRI_OFFSET_LED <= 1'b0;
			SEC_OFFSET_LED <= 1'b0;
			PRI_RATIO_LED  <= 1'b0;
			SEC_RATIO_LED  <= 1'b0;
			PRI_EXPAND_LED <= 1'b0;
			SEC_EXPAND_LED <= 1'b0;
		end else begin
			PRI_OFFSET_LED <= pri_r ? mode_reg[QR][`OSX_MODE_OFS] : mode_reg[QX][`OSX_MODE_OFS];
			PRI_RATIO_LED  <= pri_r ? mode_reg[QR][`OSX_MODE_RAT] : mode_reg[QX][`OSX_MODE_RAT];
			PRI_EXPAND_LED <= pri_r ? (mode_reg[QR][3:2] != `OSX_EXP_X1) :
				(mode_reg[QX][3:2] != `OSX_EXP_X1);
			// Phase shown: nothing is applied, so the lamps stay dark
			SEC_OFFSET_LED <= !sec_ph && mode_reg[QY][`OSX_MODE_OFS];
			SEC_RATIO_LED  <= !sec_ph && mode_reg[QY][`OSX_MODE_RAT];
			SEC_EXPAND_LED <= !sec_ph && (mode_reg[QY][3:2] != `OSX_EXP_X1);
		end
	end
endmodule
`default_nettype wire

/* File: dv/osx_top_asserts.sv */
/*
 Port-level checker for osx_top, bound into every instance.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module osx_chk (
	input wire logic               CORE_CLK,
	input wire logic               RESET,
	input wire logic               SAMPLE_VALID,
	input wire logic               RD_STB,
	input wire logic        [31:0] RD_DATA,
	input wire logic signed [15:0] PRI_OUT,
	input wire logic signed [15:0] SEC_OUT,
	input wire logic signed [15:0] X_OUT,
	input wire logic signed [15:0] PRI_BAR,
	input wire logic               OUT_VALID,
	input wire logic               OVERLOAD_LED,
	input wire logic        [11:0] DISP_FLAGS
);
	// All checks share the core clock and its reset
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);

	a_valid_follows: assert property (SAMPLE_VALID |=> OUT_VALID)
		else $error("result strobe missing after sample");
	a_valid_cause: assert property (OUT_VALID |-> $past(SAMPLE_VALID))
		else $error("result strobe without sample");
	// Outputs only move on a new sample, so displays never flicker
	a_outs_hold: assert property (!SAMPLE_VALID |=> $stable(PRI_OUT) && $stable(SEC_OUT)
		&& $stable(DISP_FLAGS))
		else $error("outputs changed without sample");
	a_bar_clamp: assert property (PRI_BAR <= 16'sd10000 && PRI_BAR >= -16'sd10000)
		else $error("bar beyond full scale");
	a_out_clamp: assert property (PRI_OUT <= 16'sd30000 && PRI_OUT >= -16'sd30000)
		else $error("output code beyond full scale");
	a_ovl_pins: assert property (OUT_VALID && DISP_FLAGS[0]
		|-> X_OUT == 16'sd30000 || X_OUT == -16'sd30000)
		else $error("overloaded output not pinned");
	a_ovl_led: assert property (OUT_VALID && (DISP_FLAGS[0] || DISP_FLAGS[4])
		|-> OVERLOAD_LED)
		else $error("overload lamp dark on overload");
	a_led_rise: assert property ($rose(OVERLOAD_LED) |-> OUT_VALID)
		else $error("overload lamp rose without sample");
	a_rd_gap: assert property (RD_DATA != 32'h0 |-> $past(RD_STB))
		else $error("read data outside its cycle");

	cover property (OUT_VALID && OVERLOAD_LED);
	cover property (OUT_VALID && DISP_FLAGS[2]);
	cover property (RD_STB ##1 RD_DATA != 32'h0);
endmodule
bind osx_top osx_chk chk_u (.CORE_CLK(CORE_CLK), .RESET(RESET), .SAMPLE_VALID(SAMPLE_VALID),
	.RD_STB(RD_STB), .RD_DATA(RD_DATA), .PRI_OUT(PRI_OUT), .SEC_OUT(SEC_OUT),
	.X_OUT(X_OUT), .PRI_BAR(PRI_BAR), .OUT_VALID(OUT_VALID),
	.OVERLOAD_LED(OVERLOAD_LED), .DISP_FLAGS(DISP_FLAGS));
`default_nettype wire

/* File: dv/osx_sink.sv */
/*
 Far-side model: output converters turning codes into millivolts.
 Assumes codes are fresh in the cycle of the valid strobe only.
*/
`timescale 1ns/1ps
`default_nettype none
module osx_sink (
	input  wire logic               clk,
	input  wire logic               vld,
	input  wire logic signed [15:0] pri_code,
	input  wire logic signed [15:0] sec_code,
	output var  logic signed [15:0] pri_mv,
	output var  logic signed [15:0] sec_mv
);
	// Converters latch on the strobe and hold until the next sample
	initial pri_mv = 16'sh0;
	initial sec_mv = 16'sh0;
	always @(posedge clk) begin
		if (vld) begin
			pri_mv <= 16'(pri_code / 3);
			sec_mv <= 16'(sec_code / 3);
		end
	end
endmodule
`default_nettype wire

/* File: dv/osx_top_tb_top.sv */
/*
 Self-checking bench for osx_top: random samples, settings and commands
 against a shadow model. Assumes the design sources under verilog/.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, s, e) begin checks++; if ((s) !== (e)) begin fail_count++; \
	$display("Error %s exp %0d got %0d", n, e, s); end end
module osx_top_tb_top;
	typedef struct {longint po, so, xo, yo, pb, sb, ps, ss; logic [11:0] fl; logic ov;} osx_exp_t;
	logic CORE_CLK = 0, RESET = 1, SAMPLE_VALID = 0, WR_STB = 0, RD_STB = 0;
	logic signed [23:0] X_IN = 0, Y_IN = 0, R_IN = 0;
	logic signed [18:0] PHASE_IN = 0;
	logic signed [15:0] AUX_IN = 16'sh3e8;
	logic [7:0] ADDR = 8'h0;
	logic [31:0] WR_DATA = 32'h0, RD_DATA, re;
	logic signed [15:0] PRI_OUT, SEC_OUT, X_OUT, Y_OUT, PRI_BAR, SEC_BAR, pri_mv, sec_mv;
	logic signed [31:0] PRI_STRIP, SEC_STRIP;
	logic SEC_OFFSET_LED, SEC_RATIO_LED;
	logic OUT_VALID, OVERLOAD_LED, PRI_OFFSET_LED, PRI_RATIO_LED, PRI_EXPAND_LED, SEC_EXPAND_LED;
	logic [11:0] DISP_FLAGS;
	// Shadow of the settings the design should hold
	longint sens = 1000000, stp = 100, ofs[3] = '{0, 0, 0}, lq[3] = '{0, 0, 0};
	logic [3:0] md[3] = '{4'h0, 4'h0, 4'h0};
	logic [1:0] ctrl = 2'h0;
	osx_exp_t eq[$], e;
	logic [31:0] rq[$], rs = 32'd22519;
	logic rd_pend = 0;
	// Previous expected codes, which the converters should be holding
	longint lpo = 0, lso = 0;
	int fail_count = 0, checks = 0;

	osx_top dut_u (.CORE_CLK(CORE_CLK), .RESET(RESET), .SAMPLE_VALID(SAMPLE_VALID),
		.X_IN(X_IN), .Y_IN(Y_IN), .R_IN(R_IN), .PHASE_IN(PHASE_IN), .AUX_IN(AUX_IN),
		.ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
		.PRI_OUT(PRI_OUT), .SEC_OUT(SEC_OUT), .X_OUT(X_OUT), .Y_OUT(Y_OUT),
		.PRI_BAR(PRI_BAR), .SEC_BAR(SEC_BAR), .PRI_STRIP(PRI_STRIP), .SEC_STRIP(SEC_STRIP),
		.OUT_VALID(OUT_VALID), .OVERLOAD_LED(OVERLOAD_LED), .PRI_OFFSET_LED(PRI_OFFSET_LED),
		.SEC_OFFSET_LED(SEC_OFFSET_LED), .PRI_RATIO_LED(PRI_RATIO_LED),
		.SEC_RATIO_LED(SEC_RATIO_LED),
		.PRI_EXPAND_LED(PRI_EXPAND_LED), .SEC_EXPAND_LED(SEC_EXPAND_LED),
		.DISP_FLAGS(DISP_FLAGS));
	osx_sink sink_u (.clk(CORE_CLK), .vld(OUT_VALID), .pri_code(PRI_OUT),
		.sec_code(SEC_OUT), .pri_mv(pri_mv), .sec_mv(sec_mv));

	always #20 CORE_CLK = ~CORE_CLK;

	function logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic longint lim(input longint v);
		return (v > 99900) ? 99900 : (v < -99900) ? -99900 : v;
	endfunction
	// One quantity's chain; returns the clamped percent, strip value and overload
	function automatic longint pth(input longint q, input int i, input longint a,
		output longint st, output logic ov);
		longint v;
		v = q * 10000 / sens;
		if (md[i][0]) v -= ofs[i];
		if (md[i][1]) v = v * 1000 / a;
		st = v;
		v *= (md[i][3:2] == 2'h2) ? 100 : (md[i][3:2] == 2'h1) ? 10 : 1;
		ov = (v > 10000) || (v < -10000);
		return ov ? ((v > 0) ? 10000 : -10000) : v;
	endfunction
	function automatic logic [3:0] flg(input int i, input logic ov);
		return {md[i][3:2] != 2'h0, md[i][1], md[i][0] && ofs[i] != 0, ov};
	endfunction

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		ADDR <= a;
		WR_DATA <= d;
		WR_STB <= 1'b1;
		@(posedge CORE_CLK);
		WR_STB <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x);
		@(posedge CORE_CLK);
		ADDR <= a;
		RD_STB <= 1'b1;
		rq.push_back(x);
		@(posedge CORE_CLK);
		RD_STB <= 1'b0;
	endtask
	task wofs(input int i, input longint v);
		wr(8'h10 + 8'(4 * i), 32'(v));
		if (v == lim(v)) ofs[i] = v;
	endtask
	// Random sample; its expected result is queued before the strobe
	task smp();
		osx_exp_t x;
		longint q[3], b[3], s[3], ph, a;
		logic o[3];
		for (int k = 0; k < 3; k++) q[k] = int'(rnd()) >>> 12;
		ph = longint'(rnd() % 360001) - 180000;
		a = longint'(200 + rnd() % 2800);
		if (rs[3]) a = -a;
		for (int k = 0; k < 3; k++) b[k] = pth(q[k], k, a, s[k], o[k]);
		x.xo = b[0] * 3;
		x.yo = b[1] * 3;
		x.po = ctrl[0] ? b[2] * 3 : b[0] * 3;
		x.pb = ctrl[0] ? b[2] : b[0];
		x.ps = ctrl[0] ? s[2] : s[0];
		x.so = ctrl[1] ? ph * 30000 / 180000 : b[1] * 3;
		x.sb = ctrl[1] ? ph * 10000 / 180000 : b[1];
		x.ss = ctrl[1] ? ph : s[1];
		x.fl = {flg(2, o[2]), flg(1, o[1]), flg(0, o[0])};
		x.ov = o[0] | o[1] | (ctrl[0] & o[2]);
		@(posedge CORE_CLK);
		X_IN <= 24'(q[0]);
		Y_IN <= 24'(q[1]);
		R_IN <= 24'(q[2]);
		PHASE_IN <= 19'(ph);
		AUX_IN <= 16'(a);
		SAMPLE_VALID <= 1'b1;
		eq.push_back(x);
		lq = q;
		@(posedge CORE_CLK);
		SAMPLE_VALID <= 1'b0;
	endtask
	// Adjustment command on a channel, then the lamps of the selection
	task cmd(input logic ch, input int b);
		int i;
		i = ch ? 1 : (ctrl[0] ? 2 : 0);
		wr(8'h0c, (32'(ch) << 8) | (32'h1 << b));
		if (!(ch && ctrl[1])) begin
			case (b)
				0: md[i][0] = !md[i][0];
				1: ofs[i] = lim(ofs[i] + stp);
				2: ofs[i] = lim(ofs[i] - stp);
				3: ofs[i] = lim(lq[i] * 10000 / sens);
				4: md[i][1] = !md[i][1];
				default: md[i][3:2] = (md[i][3:2] == 2'h2) ? 2'h0 : md[i][3:2] + 2'h1;
			endcase
		end
		repeat (2) @(posedge CORE_CLK);
		#1;
		i = ctrl[0] ? 2 : 0;
		`CHK("pri_ofs_led", PRI_OFFSET_LED, md[i][0])
		`CHK("pri_rat_led", PRI_RATIO_LED, md[i][1])
		`CHK("pri_exp_led", PRI_EXPAND_LED, md[i][3:2] != 2'h0)
		`CHK("sec_exp_led", SEC_EXPAND_LED, !ctrl[1] && md[1][3:2] != 2'h0)
		`CHK("sec_ofs_led", SEC_OFFSET_LED, !ctrl[1] && md[1][0])
		`CHK("sec_rat_led", SEC_RATIO_LED, !ctrl[1] && md[1][1])
	endtask
	task conclude();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Monitor: each result strobe retires the oldest note
	always @(posedge CORE_CLK) begin
		rd_pend <= RD_STB;
		if (rd_pend) begin
			re = rq.pop_front();
			`CHK("rd_data", RD_DATA, re)
		end
		if (OUT_VALID) begin
			`CHK("result_note", eq.size() > 0, 1'b1)
			e = eq.pop_front();
			`CHK("pri_out", PRI_OUT, e.po)
			`CHK("sec_out", SEC_OUT, e.so)
			`CHK("x_out", X_OUT, e.xo)
			`CHK("y_out", Y_OUT, e.yo)
			`CHK("pri_bar", PRI_BAR, e.pb)
			`CHK("pri_strip", PRI_STRIP, e.ps)
			`CHK("flags", DISP_FLAGS, e.fl)
			`CHK("ovl_led", OVERLOAD_LED, e.ov)
			`CHK("sec_bar", SEC_BAR, e.sb)
			`CHK("sec_strip", SEC_STRIP, e.ss)
			`CHK("pri_mv", pri_mv, lpo / 3)
			`CHK("sec_mv", sec_mv, lso / 3)
			lpo = e.po;
			lso = e.so;
		end
	end

	// Watchdog at ten thousand cycles, several times the expected run
	initial begin
		#400000;
		fail_count++;
		conclude();
	end

	initial begin
		repeat (5) @(posedge CORE_CLK);
		RESET <= 1'b0;
		rd(8'h04, 32'h000f4240);
		rd(8'h08, 32'h00000064);
		rd(8'h0c, 32'h0);
		rd(8'h40, 32'h0);
		wr(8'h04, 32'd500000);
		sens = 500000;
		wofs(0, 2500);
		cmd(1'b0, 0);
		smp();
		wr(8'h04, 32'd250000);
		sens = 250000;
		rd(8'h10, 32'd2500);
		wofs(0, 99901);
		rd(8'h10, 32'd2500);
		ctrl = 2'h2;
		wr(8'h00, 32'h2);
		cmd(1'b1, 5);
		rd(8'h00, 32'h2);
		// Expand code 3 is refused; the low mode bits still land
		wr(8'h1c, {20'h0, md[2], md[1], 4'hc});
		md[0][1:0] = 2'h0;
		rd(8'h1c, {20'h0, md[2], md[1], md[0]});
		wr(8'h08, 32'd250);
		stp = 250;
		// Random mix of samples, commands and settings
		repeat (300) begin
			case (rnd() % 6)
				0, 1: smp();
				2: cmd(rs[9], int'(rnd() % 6));
				3: wofs(int'(rnd() % 3), longint'(rnd() % 199801) - 99900);
				4: begin
					for (int k = 0; k < 3; k++) md[k] = {2'(rnd() % 3), 2'(rnd())};
					wr(8'h1c, {20'h0, md[2], md[1], md[0]});
				end
				default: begin
					ctrl = 2'(rnd());
					wr(8'h00, {30'h0, ctrl});
				end
			endcase
		end
		repeat (4) @(posedge CORE_CLK);
		`CHK("pending", eq.size() + rq.size(), 0)
		conclude();
	end
endmodule
`default_nettype wire
